/* File: rtc_core.v */
// Real-time clock: time counters, update flag, periodic request flag
//
// Contract
// - Time counters survive external reset; calendar counting goes on, free-run stops (source reloads SRC_RST).
// - Busy rises 62.5 ms before update, then clears.
// - Week, day, hour, minute, second, overflow sources.
// - Enabled request sets shared flag to 1.
// - Write 0 clears flag; stays 0 till next.
// - Overflow enable: request on each free-run overflow.
// - Week enable: request when day becomes 0.
// - Day enable: request when day advances.
// - Hour enable: request when hour advances.
// - Minute enable: request when minute advances.
// - Second enable: request when second advances.
// - Flag set only when that source enabled.
// - Hour 0-23 or 0-11 with afternoon flag.
// - Divider source (/256, /2048, /4096, /8192): 8-bit free-running counter.
// - Soft reset clears all but source select and the prescale divider.
`timescale 1ns/1ps
`include "rtc_defs.vh"
module rtc_core (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // 32.768 kHz timebase pin
  input wire timebase_32k,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Status
  output wire clock_irq_request_flag,
  output wire update_in_progress_flag
);

  localparam [14:0] PRE_TOP = 15'h7FFF;
  localparam [31:0] BUSY_LEAD = `BUSY_LEAD_TICKS;
  localparam [14:0] BUSY_START = PRE_TOP - BUSY_LEAD[14:0] + 15'h0001;

  // Timebase synchroniser and edge detect
  reg tb_s1_q;
  reg tb_s2_q;
  reg tb_s3_q;
  // Power-on values only; external reset leaves these alone
  reg [7:0] sec_q = 8'h00;
  reg [7:0] min_q = 8'h00;
  reg [7:0] hour_q = 8'h00;
  reg [7:0] dow_q = 8'h00;
  reg [14:0] pre_q = 15'h0000;
  reg run_q = 1'b0;
  reg h24_q = 1'b0;
  reg pm_q = 1'b0;
  // Control set to reset values by external reset (source select loads SRC_RST)
  reg srst_q;
  reg [5:0] en_q;
  reg [3:0] src_q;
  reg flag_q;
  reg [12:0] div_q;

  reg [12:0] div_mask;
  reg fr_tick;
  reg sec_evt;
  reg min_evt;
  reg hour_evt;
  reg day_evt;
  reg week_evt;
  reg fo_evt;
  reg [7:0] rd_d;
  wire cal_mode;
  wire tb_rise;
  wire cal_tick;
  wire busy;
  wire [7:0] hour_max;
  wire wr_flag_clear;
  wire cal_run;
  wire fr_run;
  wire pm_wrap;
  wire sec_wrap;
  wire min_wrap;
  wire hour_wrap;
  wire dow_wrap;
  wire wr_main;
  wire wr_en;
  wire wr_src;
  reg src_ok;
  reg irq_hit;

  assign cal_mode = (src_q == `SRC_CAL);
  assign tb_rise = tb_s2_q & ~tb_s3_q;
  // Counting stops outright while soft reset is held
  assign cal_run = run_q & cal_mode & ~srst_q;
  assign fr_run = run_q & ~cal_mode & ~srst_q;
  assign cal_tick = tb_rise & cal_run;
  assign hour_max = h24_q ? `H24_MAX : `H12_MAX;
  // Roll-over points of each counter
  assign sec_wrap = (sec_q >= `SEC_MAX);
  assign min_wrap = (min_q >= `MIN_MAX);
  assign hour_wrap = (hour_q >= hour_max);
  assign dow_wrap = (dow_q >= `DOW_MAX);
  // Afternoon only flips in 12-hour mode
  assign pm_wrap = ~h24_q & hour_wrap;
  // Busy window is the last 62.5 ms of each second
  assign busy = cal_run & (pre_q >= BUSY_START);
  assign update_in_progress_flag = busy;
  assign clock_irq_request_flag = flag_q;
  assign wr_flag_clear = reg_wr & (reg_addr == `ADR_FLAG) &
    ~reg_wdata[`FLAG_BIT];
  // Write decodes for the control registers
  assign wr_main = reg_wr & (reg_addr == `ADR_MAIN);
  assign wr_en = reg_wr & (reg_addr == `ADR_IRQEN);
  assign wr_src = reg_wr & (reg_addr == `ADR_SRC);

  always @(posedge ref_clk) begin
    tb_s1_q <= timebase_32k;
    tb_s2_q <= tb_s1_q;
    tb_s3_q <= tb_s2_q;
  end

  // Free-running prescale tap
  always @* begin
    src_ok = 1'b1;
    if (src_q == `SRC_D256) begin
      div_mask = 13'h00FF;
    end else if (src_q == `SRC_D2048) begin
      div_mask = 13'h07FF;
    end else if (src_q == `SRC_D4096) begin
      div_mask = 13'h0FFF;
    end else if (src_q == `SRC_D8192) begin
      div_mask = 13'h1FFF;
    end else begin
      div_mask = 13'h1FFF;
      src_ok = 1'b0;
    end
    // Undefined source codes leave the counter stopped
    fr_tick = fr_run & src_ok & ((div_q & div_mask) == div_mask);
  end

  // Calendar carry chain events
  always @* begin
    sec_evt = cal_tick & (pre_q == PRE_TOP);
    min_evt = sec_evt & sec_wrap;
    hour_evt = min_evt & min_wrap;
    day_evt = hour_evt & hour_wrap & (h24_q | pm_q);
    week_evt = day_evt & dow_wrap;
    // Free-run overflow is the seconds register wrapping
    fo_evt = fr_tick & (sec_q == 8'hFF);
  end

  // One request flag fed by every enabled source
  always @* begin
    irq_hit = 1'b0;
    if (fo_evt && en_q[`EN_FO]) begin
      irq_hit = 1'b1;
    end
    if (week_evt && en_q[`EN_WK]) begin
      irq_hit = 1'b1;
    end
    if (day_evt && en_q[`EN_DY]) begin
      irq_hit = 1'b1;
    end
    if (hour_evt && en_q[`EN_HR]) begin
      irq_hit = 1'b1;
    end
    if (min_evt && en_q[`EN_MN]) begin
      irq_hit = 1'b1;
    end
    if (sec_evt && en_q[`EN_SC]) begin
      irq_hit = 1'b1;
    end
  end

  // Time and mode registers: no external reset term
  always @(posedge ref_clk) begin
    if (srst_q) begin
      sec_q <= 8'h00;
      min_q <= 8'h00;
      hour_q <= 8'h00;
      dow_q <= 8'h00;
      pre_q <= 15'h0000;
      run_q <= 1'b0;
      h24_q <= 1'b0;
      pm_q <= 1'b0;
    end else begin
      if (cal_tick) begin
        pre_q <= pre_q + 15'h0001;
      end
      if (fr_tick) begin
        sec_q <= sec_q + 8'h01;
      end else if (sec_evt) begin
        sec_q <= min_evt ? 8'h00 : sec_q + 8'h01;
      end
      if (min_evt) begin
        min_q <= hour_evt ? 8'h00 : min_q + 8'h01;
      end
      if (hour_evt) begin
        hour_q <= hour_wrap ? 8'h00 : hour_q + 8'h01;
        if (pm_wrap) begin
          pm_q <= ~pm_q;
        end
      end
      if (day_evt) begin
        dow_q <= week_evt ? 8'h00 : dow_q + 8'h01;
      end
      // Software writes win over counting in the same cycle
      if (reg_wr) begin
        if (reg_addr == `ADR_SEC) begin
          sec_q <= reg_wdata;
          pre_q <= 15'h0000; // Restart the second on load
        end else if (reg_addr == `ADR_MIN) begin
          min_q <= reg_wdata;
        end else if (reg_addr == `ADR_HOUR) begin
          hour_q <= reg_wdata;
        end else if (reg_addr == `ADR_DOW) begin
          dow_q <= reg_wdata;
        end else if (reg_addr == `ADR_MAIN) begin
          run_q <= reg_wdata[`MAIN_RUN];
          h24_q <= reg_wdata[`MAIN_H24];
          pm_q <= reg_wdata[`MAIN_PM];
        end
      end
    end
  end

  // Control registers under external reset
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      srst_q <= 1'b0;
      en_q <= 6'h00;
      src_q <= `SRC_RST;
      flag_q <= 1'b0;
      div_q <= 13'h0000;
    end else begin
      // Divider runs always; taps pick the rate
      div_q <= div_q + 13'h0001;
      if (wr_main) begin
        srst_q <= reg_wdata[`MAIN_SRST];
      end
      // Source select survives soft reset so free-run users keep it
      if (wr_src) begin
        src_q <= reg_wdata[3:0];
      end
      if (srst_q) begin
        en_q <= 6'h00;
      end else if (wr_en) begin
        en_q <= reg_wdata[5:0];
      end
      // Set beats a same-cycle clear so no event is lost
      if (irq_hit) begin
        flag_q <= 1'b1;
      end else if (srst_q | wr_flag_clear) begin
        flag_q <= 1'b0;
      end
    end
  end

  // Read data, valid the cycle after the strobe
  always @* begin
    rd_d = 8'h00;
    if (reg_addr == `ADR_SEC) begin
      rd_d = sec_q;
    end else if (reg_addr == `ADR_MIN) begin
      rd_d = min_q;
    end else if (reg_addr == `ADR_HOUR) begin
      rd_d = hour_q;
    end else if (reg_addr == `ADR_DOW) begin
      rd_d = dow_q;
    end else if (reg_addr == `ADR_MAIN) begin
      rd_d[`MAIN_RUN] = run_q;
      rd_d[`MAIN_H24] = h24_q;
      rd_d[`MAIN_PM] = pm_q;
      rd_d[`MAIN_SRST] = srst_q;
      rd_d[`MAIN_BUSY] = busy;
    end else if (reg_addr == `ADR_IRQEN) begin
      rd_d = {2'b00, en_q};
    end else if (reg_addr == `ADR_SRC) begin
      rd_d = {4'h0, src_q};
    end else begin
      // Flag index: bit 0 only, the rest read as zero
      rd_d = {7'h00, flag_q};
    end
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      // Idle zero keeps stale data off the bus
      reg_rdata <= 8'h00;
    end
  end

endmodule

/* File: rtc_defs.vh */
// Register map, field positions, reset values and timing for the clock core
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH
`define ADR_SEC 3'h0
`define ADR_MIN 3'h1
`define ADR_HOUR 3'h2
`define ADR_DOW 3'h3
`define ADR_MAIN 3'h4
`define ADR_IRQEN 3'h5
`define ADR_SRC 3'h6
`define ADR_FLAG 3'h7
`define MAIN_RUN 7
`define MAIN_H24 6
`define MAIN_PM 5
`define MAIN_SRST 4
`define MAIN_BUSY 0
`define EN_FO 5
`define EN_WK 4
`define EN_DY 3
`define EN_HR 2
`define EN_MN 1
`define EN_SC 0
`define FLAG_BIT 0
`define SRC_RST 4'h8
`define SRC_CAL 4'h8
`define SRC_D256 4'h3
`define SRC_D2048 4'h5
`define SRC_D4096 4'h6
`define SRC_D8192 4'h7
`define TB_HZ 32768
`define BUSY_LEAD_US 62500
`define BUSY_LEAD_TICKS (`TB_HZ * `BUSY_LEAD_US / 1000000)
`define SEC_MAX 8'h3B
`define MIN_MAX 8'h3B
`define H24_MAX 8'h17
`define H12_MAX 8'h0B
`define DOW_MAX 8'h06
`endif

/* File: rtc_core_sva.sv */
// Port assertions for the clock core
`timescale 1ns/1ps
`include "rtc_defs.vh"
module rtc_core_chk (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Timebase pin and register port
  input wire timebase_32k,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Status
  input wire clock_irq_request_flag,
  input wire update_in_progress_flag
);
  wire f = clock_irq_request_flag;
  wire fw = reg_wr && reg_addr == `ADR_FLAG;
  wire sr = reg_wr && reg_addr == `ADR_MAIN && reg_wdata[`MAIN_SRST];
  wire ew = reg_wr && reg_addr == `ADR_IRQEN && reg_wdata == 8'h00;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_flag_clear: assert property (fw && !reg_wdata[0] |=> !f)
    else $error("flag kept after clear");
  a_flag_ign1: assert property (fw && reg_wdata[0] && !f |=> !f)
    else $error("flag set by write");
  a_flag_hold: assert property (f && !fw && !sr |=> f)
    else $error("flag dropped alone");
  a_soft_clr: assert property (sr |=> ##1 !f)
    else $error("flag kept in soft reset");
  // Event in flight may still land one cycle after disabling
  a_no_enable: assert property (ew && !f |=> ##1 (!f)[*7])
    else $error("flag without enable");
  a_flag_read: assert property (reg_rd && reg_addr == `ADR_FLAG
    |=> reg_rdata[0] == $past(f))
    else $error("flag read wrong");
  a_busy_read: assert property (reg_rd && reg_addr == `ADR_MAIN
    |=> reg_rdata[`MAIN_BUSY] == $past(update_in_progress_flag))
    else $error("busy read wrong");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  cover property ($rose(f));
  cover property (fw && !reg_wdata[0] && f);
  cover property (sr);
  cover property ($fell(update_in_progress_flag));
endmodule
bind rtc_core rtc_core_chk i_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .timebase_32k(timebase_32k), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clock_irq_request_flag(clock_irq_request_flag),
  .update_in_progress_flag(update_in_progress_flag));

/* File: tb_rtc_update_and_interrupt_logic.sv */
// Self-checking bench for the clock core
`timescale 1ns/1ps
`include "rtc_defs.vh"
module tb_rtc_update_and_interrupt_logic;
  reg ref_clk = 1'h0;
  reg reset_n = 1'h0;
  reg reg_wr = 1'h0;
  reg reg_rd = 1'h0;
  reg [2:0] reg_addr = 3'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg [7:0] got;
  reg [7:0] g2;
  reg tb_pin = 1'h0;
  reg tb_on = 1'h0;
  reg [18:0] rows [0:7];
  wire [7:0] reg_rdata;
  wire flag;
  wire busy;
  integer miscompares = 0;
  integer check_count = 0;
  integer i;
  // Fastest timebase: one rising edge every two clocks
  always @(posedge ref_clk) begin
    if (tb_on) begin
      tb_pin <= ~tb_pin;
    end
  end
  rtc_core i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .timebase_32k(tb_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clock_irq_request_flag(flag), .update_in_progress_flag(busy));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task chk(input [7:0] g, input [7:0] e);
    check_count = check_count + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: %h not %h", $time, g, e);
    end
  endtask
  task chk_n(input integer g, input integer e);
    check_count = check_count + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: count %0d not %0d", $time, g, e);
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input [2:0] a, output [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (75000) @(posedge ref_clk);
    miscompares = miscompares + 1;
    tally_and_finish;
  end
  initial begin
    rows[0] = {`ADR_SEC, 8'h3B, 8'h3B};
    rows[1] = {`ADR_MIN, 8'h3B, 8'h3B};
    rows[2] = {`ADR_HOUR, 8'h17, 8'h17};
    rows[3] = {`ADR_DOW, 8'h06, 8'h06};
    rows[4] = {`ADR_IRQEN, 8'h3F, 8'h3F};
    rows[5] = {`ADR_SRC, 8'h08, 8'h08};
    rows[6] = {`ADR_FLAG, 8'h01, 8'h00};
    rows[7] = {`ADR_MAIN, 8'h40, 8'h40};
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'h1;
    for (i = 0; i < 8; i = i + 1) begin
      wr(rows[i][18:16], rows[i][15:8]);
      rd(rows[i][18:16], got);
      chk(got, rows[i][7:0]);
    end
    $display("test registers done");
    wr(`ADR_SEC, 8'h2A);
    reset_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'h1;
    rd(`ADR_SEC, got);
    chk(got, 8'h2A);
    $display("test reset retention done");
    wr(`ADR_SRC, `SRC_D256);
    wr(`ADR_IRQEN, 8'h20);
    wr(`ADR_SEC, 8'hFE);
    wr(`ADR_MAIN, 8'h80);
    #1 i = 0;
    while (flag !== 1'h1 && i < 1000) begin
      #100 i = i + 1;
    end
    chk({7'h00, flag}, 8'h01);
    rd(`ADR_SEC, got);
    chk(got, 8'h00);
    repeat (254) @(posedge ref_clk);
    rd(`ADR_SEC, g2);
    chk(g2 - got, 8'h01);
    wr(`ADR_FLAG, 8'h00);
    #1 chk({7'h00, flag}, 8'h00);
    wr(`ADR_IRQEN, 8'h00);
    wr(`ADR_SEC, 8'hFE);
    repeat (600) @(posedge ref_clk);
    #1 chk({7'h00, flag}, 8'h00);
    $display("test free-run done");
    wr(`ADR_MAIN, 8'h10);
    rd(`ADR_SEC, got);
    chk(got, 8'h00);
    rd(`ADR_SRC, got);
    chk(got, {4'h0, `SRC_D256});
    wr(`ADR_MAIN, 8'h00);
    $display("test soft reset done");
    wr(`ADR_SRC, `SRC_CAL);
    wr(`ADR_MIN, 8'h3B);
    wr(`ADR_HOUR, 8'h17);
    wr(`ADR_DOW, 8'h06);
    wr(`ADR_SEC, 8'h3B);
    wr(`ADR_IRQEN, 8'h10);
    wr(`ADR_MAIN, 8'hC0);
    tb_on <= 1'h1;
    repeat (100) @(posedge ref_clk);
    reset_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'h1;
    wr(`ADR_IRQEN, 8'h10);
    #1 i = 0;
    while (busy !== 1'h1 && i < 70000) begin
      #100 i = i + 1;
    end
    chk({7'h00, busy}, 8'h01);
    rd(`ADR_MAIN, got);
    chk(got, 8'hC1);
    i = 2;
    while (busy === 1'h1 && i < 5000) begin
      #100 i = i + 1;
    end
    chk_n(i, `BUSY_LEAD_TICKS * 2);
    chk({7'h00, flag}, 8'h01);
    chk({7'h00, busy}, 8'h00);
    rd(`ADR_DOW, got);
    chk(got, 8'h00);
    rd(`ADR_HOUR, got);
    chk(got, 8'h00);
    rd(`ADR_MIN, got);
    chk(got, 8'h00);
    rd(`ADR_SEC, got);
    rd(`ADR_SEC, g2);
    chk(g2, got);
    chk(got, 8'h00);
    tb_on <= 1'h0;
    $display("test calendar roll done");
    tally_and_finish;
  end
endmodule
